// >>> transceiver_channel_pin_control.sv
// Summary of operation
// - Channel A codec is enabled when its pin or its control bit is high.
// - Loss flag A reads 1 on loss of signal and 0 on detect, only while enabled.
// - Software may route other internal functions onto loss flag A live.
// - During device reset loss flag A is driven low.
// - Loss flag A floats during pin or register power-down of channel A.
// - Channel A is powered down while its active-low pin is low.
// - During device reset the channel B serial output is a differential zero.
// - Channel B serial outputs float during pin or register power-down.
// - Rate codes 000 to 011 select full, half, quarter and eighth rate.
// - Code 101 enables auto rate sense with the clock-output selector in control.
// - Code 110 enables auto rate sense, ignores the selector and takes clock priority.
// - Code 111 follows channel A auto rate sense if the channel A rate code is 101 or 110, else the B registers.
// - The channel B rate setting governs both directions of channel B.
module transceiver_channel_pin_control import pin_ctrl_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   input wire logic device_reset_low,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // channel a pins
   input wire logic codec_enable_pin_a,
   input wire logic channel_a_powerdown_low,
   input wire logic [2:0] rate_select_a,
   input wire logic signal_detect_a,
   input wire logic auto_rate_sense_a_active,
   output logic signal_loss_flag_a,
   output logic signal_loss_flag_a_oe,
   output logic codec_active_a,
   output logic channel_a_powered_down,
   // channel b pins
   input wire logic channel_b_powerdown_low,
   input wire logic [2:0] rate_select_b,
   input wire logic serial_tx_b_data,
   output logic serial_tx_b_pos,
   output logic serial_tx_b_neg,
   output logic serial_tx_b_oe,
   output rate_decode_t rate_decode_b,
   output logic [3:0] serdes_setting_b,
   // interrupt
   output logic irq
);
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [11:0] pins_raw;
   logic [11:0] pins_sync;
   logic codec_pin_s;
   logic pd_a_low_s;
   logic pd_b_low_s;
   logic [2:0] rate_a_s;
   logic [2:0] rate_b_s;
   logic detect_s;
   logic ars_a_s;
   logic dev_rst_low_s;

   assign pins_raw = {codec_enable_pin_a, channel_a_powerdown_low, channel_b_powerdown_low,
                      rate_select_a, rate_select_b, signal_detect_a, auto_rate_sense_a_active,
                      device_reset_low};

   sync2 #(.width(12)) u_sync (
      .clk(clk),
      .srst(srst),
      .d(pins_raw),
      .q(pins_sync)
   );

   assign {codec_pin_s, pd_a_low_s, pd_b_low_s, rate_a_s, rate_b_s, detect_s, ars_a_s,
           dev_rst_low_s} = pins_sync;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [31:0] ctrl_reg;
   logic [31:0] ctrl_next;
   logic [3:0] irq_status_reg;
   logic [3:0] irq_status_next;
   logic [3:0] irq_mask_reg;
   logic [3:0] irq_mask_next;
   logic [3:0] setting_b_reg;
   logic [3:0] setting_b_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic loss_prev_reg;
   logic loss_prev_next;
   logic pd_a_prev_reg;
   logic pd_a_prev_next;
   logic [2:0] rate_b_prev_reg;
   logic [2:0] rate_b_prev_next;
   logic ready_reg;
   logic ready_next;
   logic [2:0] prime_reg;
   logic [2:0] prime_next;

   logic wr_en;
   logic rd_en;
   logic unmapped;
   logic codec_a;
   logic pd_a;
   logic pd_b;
   logic reg_pd;
   logic los_raw;
   logic los_value;
   los_src_t los_src;
   logic [3:0] events;
   logic [31:0] status_word;
   logic [31:0] rd_word;
   logic rd_first;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign rd_first = rd_en && !ready_reg;
   assign reg_pd = ctrl_reg[reg_powerdown_bit];
   assign los_src = los_src_t'(ctrl_reg[los_sel_lsb +: 2]);

   // ------------------------------------------------------------
   // channel a
   // ------------------------------------------------------------
   // pin or bit
   assign codec_a = codec_pin_s | ctrl_reg[codec_bit];
   assign pd_a = !pd_a_low_s;
   assign pd_b = !pd_b_low_s;

   assign los_raw = ctrl_reg[los_enable_bit] & !detect_s;

   always_comb begin
      case (los_src)
         los_src_detect: los_value = los_raw;
         los_src_codec: los_value = codec_a;
         los_src_powerdown: los_value = pd_a | reg_pd;
         los_src_ars: los_value = ars_a_s;
         default: los_value = los_raw;
      endcase
   end

   // ------------------------------------------------------------
   // channel b rate decode
   // ------------------------------------------------------------
   logic ars_a_mode;
   assign ars_a_mode = (rate_a_s == rate_ars) || (rate_a_s == rate_ars_priority);

   // one setting for rx and tx
   always_comb begin
      rate_decode_b = '{source: src_registers, ars_enable: 1'b0, clk_out_sel_used: 1'b1,
                        clk_out_priority: 1'b0};
      case (rate_b_s)
         rate_full: rate_decode_b.source = src_full;
         rate_half: rate_decode_b.source = src_half;
         rate_quarter: rate_decode_b.source = src_quarter;
         rate_eighth: rate_decode_b.source = src_eighth;
         rate_ars: begin
            rate_decode_b.source = src_ars_b;
            rate_decode_b.ars_enable = 1'b1;
         end
         rate_ars_priority: begin
            rate_decode_b.source = src_ars_b;
            rate_decode_b.ars_enable = 1'b1;
            rate_decode_b.clk_out_sel_used = 1'b0;
            rate_decode_b.clk_out_priority = 1'b1;
         end
         rate_slave: begin
            if (ars_a_mode) begin
               rate_decode_b.source = src_ars_a;
               rate_decode_b.ars_enable = 1'b1;
               rate_decode_b.clk_out_sel_used = 1'b0;
            end else begin
               rate_decode_b.source = src_registers;
            end
         end
         // code 100 falls back to the software setting
         default: rate_decode_b.source = src_registers;
      endcase
   end

   assign serdes_setting_b = setting_b_reg;

   // ------------------------------------------------------------
   // pin drivers
   // ------------------------------------------------------------
   always_comb begin
      signal_loss_flag_a = los_value;
      signal_loss_flag_a_oe = 1'b1;
      serial_tx_b_pos = serial_tx_b_data;
      serial_tx_b_neg = !serial_tx_b_data;
      serial_tx_b_oe = 1'b1;
      if (!dev_rst_low_s) begin
         signal_loss_flag_a = 1'b0;
      end
      if (!dev_rst_low_s) begin
         serial_tx_b_pos = 1'b0;
         serial_tx_b_neg = 1'b0;
      end
      if (pd_a || reg_pd) begin
         signal_loss_flag_a_oe = 1'b0;
      end
      if (pd_b || reg_pd) begin
         serial_tx_b_oe = 1'b0;
      end
   end

   assign codec_active_a = codec_a && !pd_a;
   assign channel_a_powered_down = pd_a;

   // ------------------------------------------------------------
   // events and apb
   // ------------------------------------------------------------
   // loss rise, loss fall, pin a release, rate b change
   // masked until the syncs hold real pins, their reset zeros would look like edges
   assign events = {4{prime_reg[2]}} & {rate_b_s != rate_b_prev_reg, pd_a_prev_reg && !pd_a,
                    loss_prev_reg && !los_raw, !loss_prev_reg && los_raw};
   assign status_word = {21'h0, rate_b_s, rate_a_s, pd_b, pd_a, los_raw, codec_a, 1'b0};

   always_comb begin
      ctrl_next = ctrl_reg;
      irq_mask_next = irq_mask_reg;
      setting_b_next = setting_b_reg;
      irq_status_next = irq_status_reg;
      prdata_next = prdata_reg;
      rd_word = 32'h0;
      unmapped = 1'b0;
      if (wr_en) begin
         if (paddr == ctrl_offset) begin
            ctrl_next = pwdata;
         end else if (paddr == irq_mask_offset) begin
            irq_mask_next = pwdata[3:0];
         end else if (paddr == setting_b_offset) begin
            setting_b_next = pwdata[3:0];
         end else if (paddr != status_offset && paddr != irq_status_offset) begin
            unmapped = 1'b1;
         end
      end
      if (rd_en) begin
         if (paddr == ctrl_offset) begin
            rd_word = ctrl_reg;
         end else if (paddr == status_offset) begin
            rd_word = status_word;
         end else if (paddr == irq_status_offset) begin
            rd_word = {28'h0, irq_status_reg};
            // clear once, on the edge that captures the word
            if (rd_first) begin
               irq_status_next = 4'h0;
            end
         end else if (paddr == irq_mask_offset) begin
            rd_word = {28'h0, irq_mask_reg};
         end else if (paddr == setting_b_offset) begin
            rd_word = {28'h0, setting_b_reg};
         end else begin
            unmapped = 1'b1;
         end
      end
      // captured in the wait cycle so it stands while pready is high
      if (rd_first) begin
         prdata_next = rd_word;
      end
      // new events win over read clear
      irq_status_next = irq_status_next | events;
      loss_prev_next = los_raw;
      pd_a_prev_next = pd_a;
      rate_b_prev_next = rate_b_s;
      ready_next = rd_first;
      prime_next = {prime_reg[1:0], 1'b1};
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_reg <= ctrl_reset;
         irq_mask_reg <= irq_mask_reset;
         setting_b_reg <= setting_b_reset;
         irq_status_reg <= 4'h0;
         prdata_reg <= 32'h0;
         loss_prev_reg <= 1'b0;
         pd_a_prev_reg <= 1'b0;
         rate_b_prev_reg <= 3'h0;
         ready_reg <= 1'b0;
         prime_reg <= 3'h0;
      end else begin
         ctrl_reg <= ctrl_next;
         irq_mask_reg <= irq_mask_next;
         setting_b_reg <= setting_b_next;
         irq_status_reg <= irq_status_next;
         prdata_reg <= prdata_next;
         loss_prev_reg <= loss_prev_next;
         pd_a_prev_reg <= pd_a_prev_next;
         rate_b_prev_reg <= rate_b_prev_next;
         ready_reg <= ready_next;
         prime_reg <= prime_next;
      end
   end

   // writes need no wait; reads take one so prdata can come from a flop
   assign pready = !rd_en || ready_reg;
   // error answer on unmapped access
   assign pslverr = psel && penable && unmapped;
   assign prdata = prdata_reg;
   assign irq = |(irq_status_reg & irq_mask_reg);
endmodule : transceiver_channel_pin_control

// >>> pin_ctrl_pkg.sv
package pin_ctrl_pkg;
   // ------------------------------------------------------------
   // apb register map
   // ------------------------------------------------------------
   localparam logic [7:0] ctrl_offset = 8'h00;
   localparam logic [7:0] status_offset = 8'h04;
   localparam logic [7:0] irq_status_offset = 8'h08;
   localparam logic [7:0] irq_mask_offset = 8'h0c;
   localparam logic [7:0] setting_b_offset = 8'h10;
   // ------------------------------------------------------------
   // control register fields
   // ------------------------------------------------------------
   localparam int codec_bit = 0;
   localparam int los_enable_bit = 1;
   localparam int reg_powerdown_bit = 2;
   localparam int los_sel_lsb = 4;
   localparam logic [31:0] ctrl_reset = 32'h0000_0002;
   localparam logic [3:0] irq_mask_reset = 4'h0;
   localparam logic [3:0] setting_b_reset = 4'h0;
   // ------------------------------------------------------------
   // rate select codes
   // ------------------------------------------------------------
   localparam logic [2:0] rate_full = 3'h0;
   localparam logic [2:0] rate_half = 3'h1;
   localparam logic [2:0] rate_quarter = 3'h2;
   localparam logic [2:0] rate_eighth = 3'h3;
   localparam logic [2:0] rate_ars = 3'h5;
   localparam logic [2:0] rate_ars_priority = 3'h6;
   localparam logic [2:0] rate_slave = 3'h7;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      los_src_detect,
      los_src_codec,
      los_src_powerdown,
      los_src_ars
   } los_src_t;
   typedef enum logic [2:0] {
      src_full,
      src_half,
      src_quarter,
      src_eighth,
      src_ars_b,
      src_ars_a,
      src_registers
   } serdes_src_t;
   typedef struct packed {
      serdes_src_t source;
      logic ars_enable;
      logic clk_out_sel_used;
      logic clk_out_priority;
   } rate_decode_t;
   typedef struct packed {
      logic tx_pos;
      logic tx_neg;
      logic tx_oe;
   } serial_out_t;
endpackage : pin_ctrl_pkg

// >>> sync2.sv
module sync2 import pin_ctrl_pkg::*; #(
   parameter int width = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // data
   input wire logic [width-1:0] d,
   output logic [width-1:0] q
);
   logic [width-1:0] meta_reg;
   logic [width-1:0] meta_next;
   logic [width-1:0] q_reg;
   logic [width-1:0] q_next;

   always_comb begin
      meta_next = d;
      q_next = meta_reg;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         meta_reg <= '0;
         q_reg <= '0;
      end else begin
         meta_reg <= meta_next;
         q_reg <= q_next;
      end
   end

   assign q = q_reg;
endmodule : sync2

// >>> pin_ctrl_asserts.sv
module pin_ctrl_asserts import pin_ctrl_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // pins in
   input wire logic device_reset_low,
   input wire logic codec_enable_pin_a,
   input wire logic channel_a_powerdown_low,
   input wire logic channel_b_powerdown_low,
   input wire logic [2:0] rate_select_b,
   // pins out
   input wire logic signal_loss_flag_a,
   input wire logic signal_loss_flag_a_oe,
   input wire logic codec_active_a,
   input wire logic channel_a_powered_down,
   input wire logic serial_tx_b_pos,
   input wire logic serial_tx_b_neg,
   input wire logic serial_tx_b_oe,
   input wire rate_decode_t rate_decode_b
);
   // ------------------------------------------------------------
   // pin relations, four cycles cover the two-flop sync
   // ------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   AST_CODEC_ON: assert property (
      (codec_enable_pin_a && channel_a_powerdown_low)[*4] |-> codec_active_a || channel_a_powered_down)
      else $error("codec not enabled by pin");
   AST_LOSS_RESET_LOW: assert property (
      (!device_reset_low)[*4] |-> !signal_loss_flag_a)
      else $error("loss flag not low in reset");
   AST_LOSS_FLOAT_PD: assert property (
      (!channel_a_powerdown_low)[*4] |-> !signal_loss_flag_a_oe)
      else $error("loss flag driven in power-down");
   AST_A_POWERED_DOWN: assert property (
      (!channel_a_powerdown_low)[*4] |-> channel_a_powered_down && !codec_active_a)
      else $error("channel a not powered down");
   AST_TX_ZERO_RESET: assert property (
      (!device_reset_low)[*4] |-> !serial_tx_b_pos && !serial_tx_b_neg)
      else $error("tx b not differential zero in reset");
   AST_TX_FLOAT_PD: assert property (
      (!channel_b_powerdown_low)[*4] |-> !serial_tx_b_oe)
      else $error("tx b driven in power-down");
   AST_RATE_EIGHTH: assert property (
      (rate_select_b == rate_eighth)[*4] |-> rate_decode_b.source == src_eighth && !rate_decode_b.ars_enable)
      else $error("eighth rate decode wrong");
   AST_RATE_PRIORITY: assert property (
      (rate_select_b == rate_ars_priority)[*4] |->
         rate_decode_b.ars_enable && rate_decode_b.clk_out_priority && !rate_decode_b.clk_out_sel_used)
      else $error("priority auto rate decode wrong");
endmodule : pin_ctrl_asserts

bind transceiver_channel_pin_control pin_ctrl_asserts u_chk (.clk(clk), .srst(srst),
   .device_reset_low(device_reset_low), .codec_enable_pin_a(codec_enable_pin_a),
   .channel_a_powerdown_low(channel_a_powerdown_low), .channel_b_powerdown_low(channel_b_powerdown_low),
   .rate_select_b(rate_select_b), .signal_loss_flag_a(signal_loss_flag_a),
   .signal_loss_flag_a_oe(signal_loss_flag_a_oe), .codec_active_a(codec_active_a),
   .channel_a_powered_down(channel_a_powered_down), .serial_tx_b_pos(serial_tx_b_pos),
   .serial_tx_b_neg(serial_tx_b_neg), .serial_tx_b_oe(serial_tx_b_oe), .rate_decode_b(rate_decode_b));

// >>> board_pins_model.sv
module board_pins_model import pin_ctrl_pkg::*; (
   // clock
   input wire logic clk,
   // wanted straps
   input wire logic [2:0] want_a,
   input wire logic [2:0] want_b,
   // strap pins
   output logic [2:0] rate_select_a,
   output logic [2:0] rate_select_b
);
   // ------------------------------------------------------------
   // strap drive, changed only after an edge
   // ------------------------------------------------------------
   initial begin
      rate_select_a = 3'h4;
      rate_select_b = 3'h0;
   end
   always @(posedge clk) begin
      rate_select_b <= want_b;
      rate_select_a <= (want_a == rate_ars_priority && want_b == rate_ars_priority) ? rate_ars : want_a;
   end
endmodule : board_pins_model

// >>> tb.sv
module tb import pin_ctrl_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, srst, device_reset_low, psel, penable, pwrite, pready, pslverr, e, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic codec_enable_pin_a, channel_a_powerdown_low, signal_detect_a, auto_rate_sense_a_active;
   logic signal_loss_flag_a, signal_loss_flag_a_oe, codec_active_a, channel_a_powered_down;
   logic channel_b_powerdown_low, serial_tx_b_data, serial_tx_b_pos, serial_tx_b_neg, serial_tx_b_oe;
   logic [2:0] rate_select_a, rate_select_b, want_a, want_b;
   logic [3:0] serdes_setting_b;
   rate_decode_t rate_decode_b;
   int num_errors, checks, cycles, seed, r;
   transceiver_channel_pin_control dut (.clk(clk), .srst(srst), .device_reset_low(device_reset_low),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .codec_enable_pin_a(codec_enable_pin_a),
      .channel_a_powerdown_low(channel_a_powerdown_low), .rate_select_a(rate_select_a),
      .signal_detect_a(signal_detect_a), .auto_rate_sense_a_active(auto_rate_sense_a_active),
      .signal_loss_flag_a(signal_loss_flag_a), .signal_loss_flag_a_oe(signal_loss_flag_a_oe),
      .codec_active_a(codec_active_a), .channel_a_powered_down(channel_a_powered_down),
      .channel_b_powerdown_low(channel_b_powerdown_low), .rate_select_b(rate_select_b),
      .serial_tx_b_data(serial_tx_b_data), .serial_tx_b_pos(serial_tx_b_pos),
      .serial_tx_b_neg(serial_tx_b_neg), .serial_tx_b_oe(serial_tx_b_oe), .rate_decode_b(rate_decode_b),
      .serdes_setting_b(serdes_setting_b), .irq(irq));
   board_pins_model board (.clk(clk), .want_a(want_a), .want_b(want_b), .rate_select_a(rate_select_a),
      .rate_select_b(rate_select_b));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         give_verdict();
      end
   end
   task automatic give_verdict;
      if (num_errors == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      checks++;
      if (g !== x) begin
         num_errors++;
         $display("BAD %0t got %h exp %h", $time, g, x);
      end
   endtask : chk
   // called just after an edge; data and error taken at the edge with pready high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      e = pslverr;
      q = prdata;
      psel <= 1'b0; penable <= 1'b0;
      // idle edge, so a next call never reassigns psel in this step
      @(posedge clk);
   endtask : apb
   task automatic ctl(input logic [1:0] s, input logic p, input logic n, input logic c);
      apb(1'b1, ctrl_offset, (32'(s) << los_sel_lsb) | (32'(p) << reg_powerdown_bit) | (32'(n) << los_enable_bit)
         | (32'(c) << codec_bit));
   endtask : ctl
   task automatic settle;
      repeat (5) @(posedge clk);
   endtask : settle
   function automatic serdes_src_t exp_src(input logic [2:0] b, input logic [2:0] a);
      if (b < 3'h4) return serdes_src_t'(b);
      if (b == rate_ars || b == rate_ars_priority) return src_ars_b;
      if (b == rate_slave && (a == rate_ars || a == rate_ars_priority)) return src_ars_a;
      return src_registers;
   endfunction : exp_src
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      seed = 5;
      srst = 1'b1; device_reset_low = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; codec_enable_pin_a = 1'b0; channel_a_powerdown_low = 1'b1; signal_detect_a = 1'b1;
      auto_rate_sense_a_active = 1'b0; channel_b_powerdown_low = 1'b1; serial_tx_b_data = 1'b0;
      want_a = 3'h4; want_b = 3'h0;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      apb(1'b0, ctrl_offset, 32'h0);
      chk(q, ctrl_reset);
      // no false edge while the syncs fill after reset
      apb(1'b0, irq_status_offset, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      chk({q[30:0], e}, 32'h1);
      apb(1'b1, setting_b_offset, 32'h5);
      apb(1'b0, setting_b_offset, 32'h0);
      chk({q[27:0], serdes_setting_b}, 32'h55);
      device_reset_low <= 1'b0; signal_detect_a <= 1'b0; serial_tx_b_data <= 1'b1;
      settle();
      chk({signal_loss_flag_a, serial_tx_b_pos, serial_tx_b_neg}, 32'h0);
      device_reset_low <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         r = $random(seed);
         codec_enable_pin_a <= r[0]; serial_tx_b_data <= r[2]; signal_detect_a <= r[3];
         auto_rate_sense_a_active <= r[4];
         ctl(r[6:5], 1'b0, 1'b1, r[1]);
         settle();
         chk(codec_active_a, r[0] | r[1]);
         chk({serial_tx_b_pos, serial_tx_b_neg, serial_tx_b_oe}, {r[2], ~r[2], 1'b1});
         chk({signal_loss_flag_a, signal_loss_flag_a_oe}, {r[6:5] == 2'h0 ? ~r[3] : r[6:5] == 2'h1 ? r[0] | r[1]
            : r[6:5] == 2'h3 ? r[4] : 1'b0, 1'b1});
      end
      signal_detect_a <= 1'b0;
      ctl(2'h0, 1'b0, 1'b1, 1'b0);
      settle();
      chk(signal_loss_flag_a, 1'b1);
      ctl(2'h0, 1'b0, 1'b0, 1'b0);
      settle();
      chk(signal_loss_flag_a, 1'b0);
      channel_a_powerdown_low <= 1'b0; channel_b_powerdown_low <= 1'b0;
      settle();
      chk({signal_loss_flag_a_oe, channel_a_powered_down, serial_tx_b_oe}, 32'h2);
      channel_a_powerdown_low <= 1'b1; channel_b_powerdown_low <= 1'b1;
      settle();
      apb(1'b0, irq_status_offset, 32'h0);
      chk(q[2], 1'b1);
      ctl(2'h0, 1'b1, 1'b1, 1'b0);
      settle();
      chk({signal_loss_flag_a_oe, serial_tx_b_oe}, 32'h0);
      ctl(2'h0, 1'b0, 1'b1, 1'b0);
      for (int c = 0; c < 8; c++) begin
         for (int k = 0; k < 2; k++) begin
            r = $random(seed);
            want_b <= c[2:0]; want_a <= k ? r[2:0] : rate_ars;
            settle();
            chk(32'(rate_decode_b.source), 32'(exp_src(rate_select_b, rate_select_a)));
            chk(rate_decode_b.ars_enable, c == 5 || c == 6
               || exp_src(rate_select_b, rate_select_a) == src_ars_a);
            if (c > 4) chk(rate_decode_b.clk_out_sel_used,
               c == 5 || (c == 7 && exp_src(rate_select_b, rate_select_a) == src_registers));
         end
      end
      // status layout: rate b, rate a, pd b, pd a, loss, codec, spare
      apb(1'b0, status_offset, 32'h0);
      chk(q, {21'h0, rate_select_b, rate_select_a, 2'h0, 1'b1, codec_enable_pin_a, 1'b0});
      apb(1'b0, irq_status_offset, 32'h0);
      apb(1'b1, irq_mask_offset, 32'h8);
      want_b <= rate_half;
      settle();
      chk(irq, 1'b1);
      apb(1'b0, irq_status_offset, 32'h0);
      chk(q & 32'h8, 32'h8);
      settle();
      chk(irq, 1'b0);
      apb(1'b1, irq_mask_offset, 32'h0);
      want_b <= rate_full;
      settle();
      chk(irq, 1'b0);
      give_verdict();
   end
endmodule : tb
